// *** cmmd_core.sv ***
`timescale 1ns/10ps
// How it works
// RULE_01: code space is read only for firmware
// RULE_02: 8192 code bytes, top 512 factory held
// RULE_03: smaller variants 4096, 2048 or 1536 bytes
// RULE_04: data RAM is 256 or 128 bytes
// RULE_05: low 128 bytes reachable direct and indirect
// RULE_06: above 0x7F direct hits registers, indirect RAM
// RULE_07: four register banks, status bits pick one
// RULE_08: indirect address comes from bank register 0/1
// RULE_09: bytes 0x20..0x2F double as 128 bits
// RULE_10: access kind decides bit versus byte
// RULE_11: push writes at pointer plus one, increments
// RULE_12: reset loads stack pointer with 0x07
// RULE_13: stack may use all of the RAM
// RULE_14: direct 0x80..0xFF reaches register space
// RULE_15: only registers ending 0 or 8 bit-addressable
// RULE_16: software keeps off unoccupied register addresses
// RULE_17: access kind alone picks code or data
// RULE_18: bank value n maps to bytes 8n..8n+7
// RULE_19: pop reads at pointer, then decrements
// RULE_20: bit addresses from 0x80 select register bits
module cmmd_core #(
    parameter int unsigned PROG_BYTES = cmmd_pkg::PROG_BYTES_LARGE,
    parameter int unsigned RAM_BYTES  = cmmd_pkg::RAM_BYTES_FULL
) (
    // clock, reset, enable
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                ce_i,
    // request from the instruction sequencer
    input  wire logic                req_valid_i,
    input  wire cmmd_pkg::cmmd_cmd_t req_cmd_i,
    input  wire logic                req_wr_i,
    input  wire logic [7:0]          req_addr_i,
    input  wire logic [2:0]          req_reg_i,
    input  wire logic [15:0]         req_code_addr_i,
    input  wire logic [7:0]          req_wdata_i,
    // answer to the sequencer
    output logic                     req_busy_o,
    output logic                     ack_o,
    output logic                     err_o,
    output logic [7:0]               rdata_o,
    // special register port toward peripherals
    output logic                     sfr_req_o,
    output logic                     sfr_wr_o,
    output logic                     sfr_bit_o,
    output logic [7:0]               sfr_addr_o,
    output logic [2:0]               sfr_bitpos_o,
    output logic [7:0]               sfr_wdata_o,
    input  wire logic [7:0]          sfr_rdata_i,
    // program memory read port
    output logic                     code_rd_o,
    output logic [15:0]              code_addr_o,
    input  wire logic [7:0]          code_data_i,
    // core state
    input  wire logic                acc_parity_i,
    output logic [7:0]               stack_top_pointer_o,
    output logic [7:0]               processor_status_byte_o
);
    import cmmd_pkg::*;
    localparam int unsigned RAM_AW = $clog2(RAM_BYTES);

    ////////////////////////////////////////////////////////////////////////////////
    // refuse sizes the decode cannot serve
    generate
        if (!(PROG_BYTES == PROG_BYTES_LARGE || PROG_BYTES == PROG_BYTES_4K ||
              PROG_BYTES == PROG_BYTES_2K || PROG_BYTES == PROG_BYTES_1K5)) begin : g_bad_prog
            $error("PROG_BYTES must be 8192, 4096, 2048 or 1536");
        end
        if (!(RAM_BYTES == RAM_BYTES_FULL || RAM_BYTES == RAM_BYTES_REDUCED)) begin : g_bad_ram
            $error("RAM_BYTES must be 256 or 128");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // storage and decode signals
    logic [7:0]        ram [RAM_BYTES];   // internal data RAM, no reset
    cmmd_state_t       state;             // sequencer state
    logic              wait_code;         // pending answer comes from code port
    cmmd_tgt_t         tgt;               // decoded target of this request
    logic [7:0]        d_addr;            // byte address inside the target
    logic              d_bit;             // single-bit access
    logic [2:0]        d_pos;             // bit position for bit access
    logic              d_write;           // request stores data
    logic [7:0]        ptr_byte;          // index register contents
    logic [7:0]        rd_val;            // read value of internal targets
    logic [1:0]        bank;              // active register bank
    logic              accept;            // request taken this edge
    logic [RAM_AW-1:0] idx;               // RAM index

    assign bank   = processor_status_byte_o[STATUS_BANK_MSB:STATUS_BANK_LSB]; // RULE_07
    assign accept = ce_i && req_valid_i && (state == ST_IDLE);
    assign idx    = d_addr[RAM_AW-1:0];
    // true when a data byte exists in the fitted RAM
    function automatic logic ram_has(input logic [7:0] a);
        ram_has = ({1'b0, a} < 9'(RAM_BYTES)); // RULE_04
    endfunction : ram_has
    // true when a code byte is fitted and open to user code
    function automatic logic code_has(input logic [15:0] a);
        logic fitted;
        logic factory;
        fitted   = ({1'b0, a} < 17'(PROG_BYTES)); // RULE_03
        factory  = (PROG_BYTES > 32'(FACTORY_FIRST)) && (a >= FACTORY_FIRST); // RULE_02
        code_has = fitted && !factory;
    endfunction : code_has

    ////////////////////////////////////////////////////////////////////////////////
    // address decode: the access kind alone picks code or data space, mode and width; direct and bit accesses pick RAM or registers by address
    always_comb begin
        tgt      = TGT_BAD;
        d_addr   = 8'h00;
        d_bit    = 1'b0;
        d_pos    = 3'h0;
        d_write  = req_wr_i;
        // index register of the active bank, working_register_zero or _one
        ptr_byte = ram[RAM_AW'({bank, 2'b00, req_reg_i[0]})]; // RULE_08
        case (req_cmd_i) // RULE_17
            CMD_CODE_READ: begin
                // table_read_instruction path
                d_write = 1'b0;
                tgt     = code_has(req_code_addr_i) ? TGT_CODE : TGT_BAD;
            end
            CMD_CODE_WRITE: begin
                // no firmware write reaches program memory
                tgt = TGT_BAD; // RULE_01
            end
            CMD_DIRECT: begin
                d_addr = req_addr_i;
                if (req_addr_i < SFR_FIRST) begin
                    tgt = TGT_RAM; // RULE_05
                end else if (req_addr_i == ADDR_STACK_PTR) begin
                    tgt = TGT_STACK; // RULE_14
                end else if (req_addr_i == ADDR_STATUS) begin
                    tgt = TGT_STATUS;
                end else begin
                    tgt = TGT_SFR; // RULE_06
                end
            end
            CMD_INDIRECT: begin
                // upper half only exists on the full RAM
                d_addr = ptr_byte;
                tgt    = ram_has(ptr_byte) ? TGT_RAM : TGT_BAD; // RULE_06
            end
            CMD_REG: begin
                d_addr = {3'b000, bank, req_reg_i}; // RULE_18
                tgt    = TGT_RAM;
            end
            CMD_BIT: begin
                d_bit = 1'b1; // RULE_10
                d_pos = req_addr_i[2:0];
                if (!req_addr_i[7]) begin
                    d_addr = {BIT_RAM_HIGH, req_addr_i[6:3]}; // RULE_09
                    tgt    = TGT_RAM;
                end else begin
                    // bit encoding can only name registers ending in 0 or 8
                    d_addr = {req_addr_i[7:3], 3'b000}; // RULE_15 RULE_20
                    tgt    = (d_addr == ADDR_STATUS) ? TGT_STATUS : TGT_SFR;
                end
            end
            CMD_PUSH: begin
                d_addr  = stack_top_pointer_o + 8'h01; // RULE_11
                d_write = 1'b1;
                tgt     = ram_has(d_addr) ? TGT_RAM : TGT_BAD; // RULE_13
            end
            CMD_POP: begin
                d_addr  = stack_top_pointer_o; // RULE_19
                d_write = 1'b0;
                tgt     = ram_has(d_addr) ? TGT_RAM : TGT_BAD; // RULE_13
            end
            default: begin
                tgt = TGT_BAD;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read value of the internal targets
    always_comb begin
        case (tgt)
            TGT_RAM:    rd_val = d_bit ? {7'h00, ram[idx][d_pos]} : ram[idx];
            TGT_STACK:  rd_val = stack_top_pointer_o;
            TGT_STATUS: rd_val = d_bit ? {7'h00, processor_status_byte_o[d_pos]} : processor_status_byte_o;
            default: rd_val = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // data RAM writes; bit writes change one bit and keep the rest
    always_ff @(posedge clk_i) begin
        if (accept && tgt == TGT_RAM && d_write) begin
            if (d_bit) begin
                ram[idx][d_pos] <= req_wdata_i[0]; // RULE_09
            end else begin
                ram[idx] <= req_wdata_i; // RULE_11
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // stack pointer: always names the last used byte
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            stack_top_pointer_o <= STACK_PTR_RESET; // RULE_12
        end else if (accept) begin
            if (req_cmd_i == CMD_PUSH && tgt == TGT_RAM) begin
                stack_top_pointer_o <= stack_top_pointer_o + 8'h01; // RULE_11
            end else if (req_cmd_i == CMD_POP && tgt == TGT_RAM) begin
                stack_top_pointer_o <= stack_top_pointer_o - 8'h01; // RULE_19
            end else if (tgt == TGT_STACK && d_write) begin
                // software may move the stack anywhere
                stack_top_pointer_o <= req_wdata_i; // RULE_13
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // status byte; parity follows the accumulator and ignores writes
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            processor_status_byte_o <= STATUS_RESET;
        end else if (ce_i) begin
            processor_status_byte_o[STATUS_PARITY_POS] <= acc_parity_i;
            if (accept && tgt == TGT_STATUS && d_write) begin
                if (!d_bit) begin
                    processor_status_byte_o[7:1] <= req_wdata_i[7:1]; // RULE_07
                end else if (d_pos != STATUS_PARITY_POS) begin
                    processor_status_byte_o[d_pos] <= req_wdata_i[0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sequencer: internal targets answer next cycle, ports one cycle later
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state      <= ST_IDLE;
            wait_code  <= 1'b0;
            req_busy_o <= 1'b0;
            ack_o      <= 1'b0;
            err_o      <= 1'b0;
            rdata_o    <= 8'h00;
        end else if (ce_i) begin
            ack_o <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (accept) begin
                        if (tgt == TGT_SFR || tgt == TGT_CODE) begin
                            // wait for the port's data
                            state      <= ST_WAIT;
                            req_busy_o <= 1'b1;
                            wait_code  <= (tgt == TGT_CODE);
                        end else begin
                            ack_o   <= 1'b1;
                            err_o   <= (tgt == TGT_BAD); // RULE_01
                            rdata_o <= rd_val;
                        end
                    end
                end
                ST_WAIT: begin
                    // port data is sampled one cycle after its strobe
                    state      <= ST_IDLE;
                    req_busy_o <= 1'b0;
                    ack_o      <= 1'b1;
                    err_o      <= 1'b0;
                    rdata_o    <= wait_code ? code_data_i : sfr_rdata_i;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // special register strobe; unoccupied addresses are passed on unfiltered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sfr_req_o    <= 1'b0;
            sfr_wr_o     <= 1'b0;
            sfr_bit_o    <= 1'b0;
            sfr_addr_o   <= 8'h00;
            sfr_bitpos_o <= 3'h0;
            sfr_wdata_o  <= 8'h00;
        end else if (ce_i) begin
            sfr_req_o <= accept && tgt == TGT_SFR; // RULE_14
            if (accept && tgt == TGT_SFR) begin
                sfr_wr_o     <= d_write;
                sfr_bit_o    <= d_bit; // RULE_15
                sfr_addr_o   <= d_addr;
                sfr_bitpos_o <= d_pos;
                sfr_wdata_o  <= req_wdata_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // program memory strobe, read only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            code_rd_o   <= 1'b0;
            code_addr_o <= 16'h0000;
        end else if (ce_i) begin
            code_rd_o <= accept && tgt == TGT_CODE; // RULE_01
            if (accept && tgt == TGT_CODE) begin
                code_addr_o <= req_code_addr_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    property p_code_write;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_CODE_WRITE |=> ack_o && err_o && !code_rd_o;
    endproperty
    a_code_write: assert property (p_code_write) else $error("code write not refused"); // RULE_01
    property p_factory;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_CODE_READ && PROG_BYTES == PROG_BYTES_LARGE &&
        req_code_addr_i >= FACTORY_FIRST |=> err_o && !code_rd_o;
    endproperty
    a_factory: assert property (p_factory) else $error("factory bytes reached"); // RULE_02
    property p_code_fit;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_CODE_READ && code_has(req_code_addr_i)
        |=> code_rd_o && code_addr_o == $past(req_code_addr_i) ##1 ack_o && !err_o;
    endproperty
    a_code_fit: assert property (p_code_fit) else $error("code read not served"); // RULE_03
    property p_direct_sfr;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_DIRECT && req_addr_i >= SFR_FIRST &&
        req_addr_i != ADDR_STACK_PTR && req_addr_i != ADDR_STATUS
        |=> sfr_req_o && !sfr_bit_o && sfr_addr_o == $past(req_addr_i);
    endproperty
    a_direct_sfr: assert property (p_direct_sfr) else $error("direct access missed registers"); // RULE_14
    property p_bit_sfr;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_BIT && req_addr_i[7] && {req_addr_i[7:3], 3'b000} != ADDR_STATUS
        |=> sfr_req_o && sfr_bit_o && sfr_addr_o[2:0] == 3'h0 && sfr_bitpos_o == $past(req_addr_i[2:0]);
    endproperty
    a_bit_sfr: assert property (p_bit_sfr) else $error("register bit select wrong"); // RULE_20
    property p_push;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_PUSH && tgt == TGT_RAM
        |=> stack_top_pointer_o == $past(stack_top_pointer_o) + 8'h01 && ack_o && !err_o;
    endproperty
    a_push: assert property (p_push) else $error("push did not advance pointer"); // RULE_11
    property p_pop;
        @(posedge clk_i) disable iff (rst_i)
        accept && req_cmd_i == CMD_POP && tgt == TGT_RAM
        |=> stack_top_pointer_o == $past(stack_top_pointer_o) - 8'h01 && ack_o;
    endproperty
    a_pop: assert property (p_pop) else $error("pop did not retreat pointer"); // RULE_19
    property p_reset_sp;
        @(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> stack_top_pointer_o == STACK_PTR_RESET;
    endproperty
    a_reset_sp: assert property (p_reset_sp) else $error("stack pointer reset wrong"); // RULE_12
    property p_wait_ack;
        @(posedge clk_i) disable iff (rst_i)
        sfr_req_o && ce_i |=> ack_o && !req_busy_o;
    endproperty
    a_wait_ack: assert property (p_wait_ack) else $error("register answer late"); // RULE_06

endmodule : cmmd_core

// *** cmmd_pkg.sv ***
package cmmd_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // program space
    localparam int unsigned PROG_SPACE_BYTES  = 65536;   // whole code address space
    localparam int unsigned PROG_BYTES_LARGE  = 8192;    // largest variant
    localparam int unsigned PROG_BYTES_4K     = 4096;    // smaller variants
    localparam int unsigned PROG_BYTES_2K     = 2048;
    localparam int unsigned PROG_BYTES_1K5    = 1536;
    localparam logic [15:0] FACTORY_FIRST     = 16'h1E00; // start of factory-held bytes

    ////////////////////////////////////////////////////////////////////////////////
    // data space
    localparam int unsigned RAM_BYTES_FULL    = 256;
    localparam int unsigned RAM_BYTES_REDUCED = 128;
    localparam logic [7:0]  SFR_FIRST         = 8'h80;   // direct addresses from here are special registers
    localparam logic [7:0]  ADDR_STACK_PTR    = 8'h81;
    localparam logic [7:0]  ADDR_STATUS       = 8'hD0;
    localparam logic [3:0]  BIT_RAM_HIGH      = 4'h2;    // bit bytes live at 0x20..0x2F
    localparam logic [7:0]  STACK_PTR_RESET   = 8'h07;
    localparam logic [7:0]  STATUS_RESET      = 8'h00;
    localparam int unsigned STATUS_BANK_LSB   = 3;       // bank_select_low position
    localparam int unsigned STATUS_BANK_MSB   = 4;       // bank_select_high position
    localparam logic [2:0]  STATUS_PARITY_POS = 3'h0;    // read-only parity bit

    ////////////////////////////////////////////////////////////////////////////////
    // access kinds, decoded targets, sequencer states
    typedef enum logic [2:0] {
        CMD_CODE_READ, CMD_CODE_WRITE, CMD_DIRECT, CMD_INDIRECT,
        CMD_REG, CMD_BIT, CMD_PUSH, CMD_POP
    } cmmd_cmd_t;

    typedef enum logic [2:0] {
        TGT_RAM, TGT_STACK, TGT_STATUS, TGT_SFR, TGT_CODE, TGT_BAD
    } cmmd_tgt_t;

    typedef enum logic {
        ST_IDLE, ST_WAIT
    } cmmd_state_t;

endpackage : cmmd_pkg

// *** cmmd_far_model.sv ***
`timescale 1ns/10ps
// peripheral register file and program store seen from the decoder's far side
module cmmd_far_model (
    // clock
    input  wire logic        clk_i,
    // special register port
    input  wire logic        sfr_req_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_bit_i,
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic [2:0]  sfr_bitpos_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    // program memory port
    input  wire logic        code_rd_i,
    input  wire logic [15:0] code_addr_i,
    output logic      [7:0]  code_data_o
);
    logic [7:0] regs [256];  // register contents, seeded with addr ^ 5A
    logic [7:0] last_sfr;    // last value put on the read bus
    logic [7:0] last_code;   // last program byte returned
    ////////////////////////////////////////////////////////////////////////////////
    // seed every register so reads are predictable without a prior write
    initial begin
        for (int i = 0; i < 256; i++) begin
            regs[i] = 8'(i) ^ 8'h5A;
        end
        last_sfr = 8'h00;
        last_code = 8'h00;
    end
    // bit writes arrive as position plus data bit0; the model does the merge
    always @(posedge clk_i) begin
        if (sfr_req_i && sfr_wr_i) begin
            if (sfr_bit_i) regs[sfr_addr_i][sfr_bitpos_i] <= sfr_wdata_i[0];
            else regs[sfr_addr_i] <= sfr_wdata_i;
        end
        if (sfr_req_i) last_sfr <= sfr_rdata_o;
        if (code_rd_i) last_code <= code_data_o;
    end
    // outside a strobe the buses show the inverse of the last value, never stale data
    assign sfr_rdata_o = sfr_req_i ? regs[sfr_addr_i] : ~last_sfr;
    assign code_data_o = code_rd_i ? (code_addr_i[7:0] ^ code_addr_i[15:8] ^ 8'hC3) : ~last_code;
endmodule : cmmd_far_model

// *** cmmd_core_tb.sv ***
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
    $display("BAD %s exp %0h got %0h", nm, exp, got); end end
module cmmd_core_tb;
    import cmmd_pkg::*;
    logic clk, rst, ce, valid, wr, busy, ack, err, sfr_req, sfr_wr, sfr_bit, code_rd, parity;
    cmmd_cmd_t   cmd;
    logic [7:0]  addr, wd, rdata, sfr_addr, sfr_wd, sfr_rd, code_data, stp, st, got, cap_addr;
    logic [2:0]  rg, sfr_pos, cap_pos;
    logic [15:0] pa, code_addr;
    logic        gerr, cap_bit, cap_busy, cap_wr;
    int          lat, errors, check_count;
    ////////////////////////////////////////////////////////////////////////////////
    cmmd_core #(.PROG_BYTES(PROG_BYTES_LARGE), .RAM_BYTES(RAM_BYTES_FULL)) u_dut (
        .clk_i(clk), .rst_i(rst), .ce_i(ce), .req_valid_i(valid), .req_cmd_i(cmd), .req_wr_i(wr),
        .req_addr_i(addr), .req_reg_i(rg), .req_code_addr_i(pa), .req_wdata_i(wd), .req_busy_o(busy),
        .ack_o(ack), .err_o(err), .rdata_o(rdata), .sfr_req_o(sfr_req), .sfr_wr_o(sfr_wr),
        .sfr_bit_o(sfr_bit), .sfr_addr_o(sfr_addr), .sfr_bitpos_o(sfr_pos), .sfr_wdata_o(sfr_wd),
        .sfr_rdata_i(sfr_rd), .code_rd_o(code_rd), .code_addr_o(code_addr), .code_data_i(code_data),
        .acc_parity_i(parity), .stack_top_pointer_o(stp), .processor_status_byte_o(st));
    cmmd_far_model u_far (
        .clk_i(clk), .sfr_req_i(sfr_req), .sfr_wr_i(sfr_wr), .sfr_bit_i(sfr_bit), .sfr_addr_i(sfr_addr),
        .sfr_bitpos_i(sfr_pos), .sfr_wdata_i(sfr_wd), .sfr_rdata_o(sfr_rd), .code_rd_i(code_rd),
        .code_addr_i(code_addr), .code_data_o(code_data));
    ////////////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // verdict and end of run, shared with the watchdog
    task automatic complete_run;
        if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    // request stays up until its answer (a busy sequencer ignores it); valid is never dropped
    // and raised in one step, so the next call must follow at once; the port strobe is captured
    task automatic acc(input cmmd_cmd_t c, input logic w, input logic [7:0] a, input logic [2:0] r,
                       input logic [15:0] p, input logic [7:0] d);
        valid = 1'b1; cmd = c; wr = w; addr = a; rg = r; pa = p; wd = d;
        @(posedge clk); #1;
        cap_busy = busy;
        lat = 1;
        while (ack !== 1'b1 && lat < 8) begin
            if (sfr_req === 1'b1) begin
                cap_bit = sfr_bit; cap_addr = sfr_addr; cap_pos = sfr_pos;
                cap_wr = sfr_wr;
            end
            @(posedge clk); #1;
            lat++;
        end
        if (lat >= 8) begin errors++; $display("BAD ack exp 1 got 0"); end
        got = rdata; gerr = err;
    endtask : acc
    // push then pop from the reset pointer
    task automatic t_stack;
        `CHK("ptr_reset", 8'h07, stp)
        acc(CMD_PUSH, 1'b1, 8'h00, 3'h0, 16'h0, 8'hAA);
        `CHK("push_ptr", 8'h08, stp)
        `CHK("push_busy", 1'b0, cap_busy)
        acc(CMD_DIRECT, 1'b0, 8'h08, 3'h0, 16'h0, 8'h00);
        `CHK("push_ram", 8'hAA, got)
        acc(CMD_POP, 1'b0, 8'h00, 3'h0, 16'h0, 8'h00);
        `CHK("pop_data", 8'hAA, got)
        `CHK("pop_ptr", 8'h07, stp)
    endtask : t_stack
    // every bank value; parity bit is read only and follows the input
    task automatic t_banks;
        parity = 1'b1;
        for (int b = 0; b < 4; b++) begin
            acc(CMD_DIRECT, 1'b1, ADDR_STATUS, 3'h0, 16'h0, {3'h0, 2'(b), 3'h0});
            `CHK("bank_bits", 2'(b), st[4:3])
            acc(CMD_REG, 1'b1, 8'h00, 3'h3, 16'h0, 8'h40 + 8'(b));
            acc(CMD_DIRECT, 1'b0, 8'(b * 8 + 3), 3'h0, 16'h0, 8'h00);
            `CHK("bank_ram", 8'h40 + 8'(b), got)
            acc(CMD_DIRECT, 1'b0, ADDR_STATUS, 3'h0, 16'h0, 8'h00);
            `CHK("status_rd", {3'h0, 2'(b), 3'h1}, got)
        end
        acc(CMD_DIRECT, 1'b1, ADDR_STATUS, 3'h0, 16'h0, 8'h00);
        acc(CMD_BIT, 1'b1, 8'hD3, 3'h0, 16'h0, 8'h01);
        `CHK("bank_bit", 2'h1, st[4:3])
        acc(CMD_BIT, 1'b0, 8'hD0, 3'h0, 16'h0, 8'h00);
        `CHK("parity_bit", 9'h001, {gerr, got})
        acc(CMD_BIT, 1'b1, 8'hD3, 3'h0, 16'h0, 8'h00);
        `CHK("bank_bit_clr", 2'h0, st[4:3])
    endtask : t_banks
    // upper addresses: indirect hits RAM, direct hits a peripheral register
    task automatic t_upper;
        acc(CMD_REG, 1'b1, 8'h00, 3'h1, 16'h0, 8'h99);
        acc(CMD_INDIRECT, 1'b1, 8'h00, 3'h1, 16'h0, 8'h5E);
        acc(CMD_INDIRECT, 1'b0, 8'h00, 3'h1, 16'h0, 8'h00);
        `CHK("ind_upper", 8'h5E, got)
        acc(CMD_DIRECT, 1'b0, 8'h99, 3'h0, 16'h0, 8'h00);
        `CHK("dir_upper", 8'hC3, got)
        `CHK("dir_lat", 2, lat)
        `CHK("dir_addr", 8'h99, cap_addr)
        `CHK("byte_only", 1'b0, cap_bit)
        `CHK("dir_busy", 1'b1, cap_busy)
        `CHK("dir_rd", 1'b0, cap_wr)
    endtask : t_upper
    // bit space in RAM and in a bit-addressable register
    task automatic t_bits;
        acc(CMD_DIRECT, 1'b1, 8'h22, 3'h0, 16'h0, 8'h00);
        acc(CMD_BIT, 1'b1, 8'h13, 3'h0, 16'h0, 8'h01);
        acc(CMD_DIRECT, 1'b0, 8'h22, 3'h0, 16'h0, 8'h00);
        `CHK("bit_byte", 8'h08, got)
        acc(CMD_BIT, 1'b0, 8'h13, 3'h0, 16'h0, 8'h00);
        `CHK("bit_read", 8'h01, got)
        acc(CMD_BIT, 1'b1, 8'h9B, 3'h0, 16'h0, 8'h01);
        `CHK("sfr_bit", 1'b1, cap_bit)
        `CHK("sfr_bit_addr", 8'h98, cap_addr)
        `CHK("sfr_bit_pos", 3'h3, cap_pos)
        `CHK("sfr_bit_wr", 1'b1, cap_wr)
        acc(CMD_DIRECT, 1'b0, 8'h98, 3'h0, 16'h0, 8'h00);
        `CHK("sfr_merge", 8'hCA, got)
    endtask : t_bits
    // program space: read only, factory block refused, separate from data
    task automatic t_code;
        acc(CMD_CODE_READ, 1'b0, 8'h00, 3'h0, 16'h0022, 8'h00);
        `CHK("code_rd", 8'hE1, got)
        `CHK("code_lat", 2, lat)
        `CHK("code_busy", 1'b1, cap_busy)
        acc(CMD_CODE_WRITE, 1'b1, 8'h00, 3'h0, 16'h0022, 8'h55);
        `CHK("code_wr_err", 1'b1, gerr)
        acc(CMD_CODE_READ, 1'b0, 8'h00, 3'h0, 16'h1DFF, 8'h00);
        `CHK("code_top", 9'h021, {gerr, got})
        acc(CMD_CODE_READ, 1'b0, 8'h00, 3'h0, FACTORY_FIRST, 8'h00);
        `CHK("factory_err", 1'b1, gerr)
        acc(CMD_CODE_READ, 1'b0, 8'h00, 3'h0, 16'h2000, 8'h00);
        `CHK("unfit_err", 1'b1, gerr)
    endtask : t_code
    // stack reaching the last RAM byte
    task automatic t_stack_top;
        acc(CMD_DIRECT, 1'b1, ADDR_STACK_PTR, 3'h0, 16'h0, 8'hFE);
        acc(CMD_PUSH, 1'b1, 8'h00, 3'h0, 16'h0, 8'h77);
        `CHK("ptr_top", 8'hFF, stp)
        acc(CMD_REG, 1'b1, 8'h00, 3'h0, 16'h0, 8'hFF);
        acc(CMD_INDIRECT, 1'b0, 8'h00, 3'h0, 16'h0, 8'h00);
        `CHK("ram_ff", 9'h077, {gerr, got})
        acc(CMD_POP, 1'b0, 8'h00, 3'h0, 16'h0, 8'h00);
        `CHK("pop_top", 8'hFE, stp)
    endtask : t_stack_top
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under 400 cycles
    initial begin
        #(40 * 2000);
        errors++;
        complete_run();
    end
    // reset for two cycles, then every scenario; only the clock enable stays tied
    initial begin
        errors = 0; check_count = 0;
        rst = 1'b1; ce = 1'b1; valid = 1'b0; cmd = CMD_DIRECT; wr = 1'b0; addr = 8'h00;
        rg = 3'h0; pa = 16'h0000; wd = 8'h00; parity = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst = 1'b0;
        `CHK("status_reset", STATUS_RESET, st)
        t_stack();
        t_banks();
        t_upper();
        t_bits();
        t_code();
        t_stack_top();
        complete_run();
    end
endmodule : cmmd_core_tb
